// >>> core/pio_port_decoder.sv
// Port address decoder with latched I/O ports, sense input and command ports
`default_nettype none
`include "pio_cfg.svh"
module pio_port_decoder (
  input  wire logic                   clk_i,
  input  wire logic                   rstn_i,
  // Instruction sequencer side
  input  wire logic                   io_req_i,
  input  wire pio_pkg::pio_op_t       op_i,
  input  wire logic [4:0]             port_addr_i,
  input  wire logic [3:0]             wdata_i,
  input  wire logic [1:0]             bit_sel_i,
  input  wire logic [3:0]             lreg_i,
  input  wire logic                   cyc2_i,
  input  wire logic [1:0]             state_i,
  output logic      [3:0]             rdata_o,
  output logic                        test_o,
  output logic                        rvalid_o,
  output logic                        illegal_o,
  // Pins
  input  wire logic [3:0]             wide_port_a_i,
  output logic      [3:0]             wide_port_a_o,
  output logic      [3:0]             wide_port_a_oe_o,
  input  wire logic [3:0]             wide_port_b_i,
  output logic      [3:0]             wide_port_b_o,
  output logic      [3:0]             wide_port_b_oe_o,
  input  wire logic [1:0]             narrow_shared_port_i,
  output logic      [1:0]             narrow_shared_port_o,
  output logic      [1:0]             narrow_shared_port_oe_o,
  input  wire logic                   sense_input_port_i,
  // Command registers toward internal circuits
  output logic      [3:0]             hold_mode_command_o,
  output logic      [3:0]             interval_timer_command_o,
  output logic      [3:0]             counter_one_command_o,
  output logic      [3:0]             counter_two_command_o
);
  import pio_pkg::*;

  typedef struct packed {
    logic [3:0] lat_a;
    logic [3:0] lat_b;
    logic [1:0] lat_n;
    logic [3:0] rdata;
    logic       test;
    logic       rvalid;
    logic       illegal;
    logic       cyc2_q;
    logic [1:0] state_q;
    logic       cmd_we;
    logic [1:0] cmd_idx;
    logic [3:0] cmd_wd;
  } pio_state_t;

  pio_state_t s_r;
  pio_state_t s_nxt;
  logic [15:0] cmd_q;
  logic        s3_hit;
  logic        s4_hit;
  logic        legal;

  ////////////////////////////////////////////////////////////////////////
  // Decode helpers

  // Which instruction form each port address accepts
  function automatic logic form_ok(input pio_op_t op, input logic [4:0] a);
    logic lat;
    logic cmd;
    lat = (a == `PIO_ADDR_WIDE_A) || (a == `PIO_ADDR_WIDE_B) ||
          (a == `PIO_ADDR_NARROW);
    cmd = (a == `PIO_ADDR_HOLD) || (a == `PIO_ADDR_ITMR) ||
          (a == `PIO_ADDR_CNT1) || (a == `PIO_ADDR_CNT2);
    case (op)
      PIO_OP_IN:    form_ok = lat || (a == `PIO_ADDR_SENSE);
      PIO_OP_OUT:   form_ok = lat || cmd;
      PIO_OP_OUTK:  form_ok = lat;
      PIO_OP_SETP:  form_ok = lat;
      PIO_OP_CLRP:  form_ok = lat;
      PIO_OP_TESTP: form_ok = lat;
      PIO_OP_SETL:  form_ok = (lreg_i[3:2] == `PIO_LREG_PORT_A) ||
                              (lreg_i[3:2] == `PIO_LREG_PORT_B);
      PIO_OP_CLRL:  form_ok = (lreg_i[3:2] == `PIO_LREG_PORT_A) ||
                              (lreg_i[3:2] == `PIO_LREG_PORT_B);
      PIO_OP_TESTL: form_ok = (lreg_i[3:2] == `PIO_LREG_PORT_A) ||
                              (lreg_i[3:2] == `PIO_LREG_PORT_B);
      default:      form_ok = 1'b0;
    endcase
  endfunction

  // Pin value of an input address, sense inverted; no capture latch, no filter
  function automatic logic [3:0] pin_read(input logic [4:0] a);
    case (a)
      `PIO_ADDR_WIDE_A: pin_read = wide_port_a_i;
      `PIO_ADDR_WIDE_B: pin_read = wide_port_b_i;
      `PIO_ADDR_NARROW: pin_read = {2'h0, narrow_shared_port_i};
      `PIO_ADDR_SENSE:  pin_read = {3'h0, ~sense_input_port_i};
      default:          pin_read = `PIO_UNDEF_READ;
    endcase
  endfunction

  // Map indirect L value to port address; the bit comes from L[1:0]
  function automatic logic [4:0] lreg_addr(input logic [3:0] l);
    lreg_addr = (l[3:2] == `PIO_LREG_PORT_A) ? `PIO_ADDR_WIDE_A : `PIO_ADDR_WIDE_B;
  endfunction

  // One latch bit set or cleared, others kept
  function automatic logic [3:0] bit_upd(input logic [3:0] v, input logic [1:0] b,
                                         input logic val);
    logic [3:0] r;
    r = v;
    r[b] = val;
    bit_upd = r;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // State strobes: act on first clock of each state only

  assign legal  = form_ok(op_i, port_addr_i);
  assign s3_hit = io_req_i && cyc2_i && (state_i == `PIO_ST_SAMPLE) &&
                  !(s_r.cyc2_q && (s_r.state_q == `PIO_ST_SAMPLE));
  assign s4_hit = io_req_i && cyc2_i && (state_i == `PIO_ST_DRIVE) &&
                  !(s_r.cyc2_q && (s_r.state_q == `PIO_ST_DRIVE));

  ////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    logic [4:0] la;
    logic [3:0] cur;
    la = lreg_addr(lreg_i);
    cur = '0;
    s_nxt = s_r;
    s_nxt.cyc2_q  = cyc2_i;
    s_nxt.state_q = state_i;
    s_nxt.rvalid  = 1'b0;
    s_nxt.illegal = 1'b0;
    s_nxt.cmd_we  = 1'b0;
    // Reads: sampled in the sample state, forms checked here
    if (s3_hit) begin
      if (!legal) begin
        s_nxt.illegal = 1'b1;
      end else begin
        case (op_i)
          PIO_OP_IN: begin
            s_nxt.rdata  = pin_read(port_addr_i);
            s_nxt.rvalid = 1'b1;
          end
          PIO_OP_TESTP: begin
            cur = pin_read(port_addr_i);
            s_nxt.test   = cur[bit_sel_i];
            s_nxt.rvalid = 1'b1;
          end
          PIO_OP_TESTL: begin
            cur = pin_read(la);
            s_nxt.test   = cur[lreg_i[1:0]];
            s_nxt.rvalid = 1'b1;
          end
          default: begin
            s_nxt.rvalid = 1'b0;
          end
        endcase
      end
    end
    // Writes: latches change only in the drive state
    if (s4_hit && legal) begin
      case (op_i)
        PIO_OP_OUT, PIO_OP_OUTK: begin
          case (port_addr_i)
            `PIO_ADDR_WIDE_A: s_nxt.lat_a = wdata_i;
            `PIO_ADDR_WIDE_B: s_nxt.lat_b = wdata_i;
            `PIO_ADDR_NARROW: s_nxt.lat_n = wdata_i[1:0];
            `PIO_ADDR_HOLD: begin
              s_nxt.cmd_we  = 1'b1;
              s_nxt.cmd_idx = `PIO_CMD_IDX_HOLD;
            end
            `PIO_ADDR_ITMR: begin
              s_nxt.cmd_we  = 1'b1;
              s_nxt.cmd_idx = `PIO_CMD_IDX_ITMR;
            end
            `PIO_ADDR_CNT1: begin
              s_nxt.cmd_we  = 1'b1;
              s_nxt.cmd_idx = `PIO_CMD_IDX_CNT1;
            end
            `PIO_ADDR_CNT2: begin
              s_nxt.cmd_we  = 1'b1;
              s_nxt.cmd_idx = `PIO_CMD_IDX_CNT2;
            end
            default: begin
              s_nxt.cmd_we = 1'b0;
            end
          endcase
          s_nxt.cmd_wd = wdata_i;
        end
        PIO_OP_SETP, PIO_OP_CLRP: begin
          case (port_addr_i)
            `PIO_ADDR_WIDE_A: s_nxt.lat_a = bit_upd(s_r.lat_a, bit_sel_i, op_i == PIO_OP_SETP);
            `PIO_ADDR_WIDE_B: s_nxt.lat_b = bit_upd(s_r.lat_b, bit_sel_i, op_i == PIO_OP_SETP);
            default: begin
              cur = bit_upd({2'h0, s_r.lat_n}, bit_sel_i, op_i == PIO_OP_SETP);
              // Bits above the two pins have no latch here
              if (!bit_sel_i[1]) begin
                s_nxt.lat_n = cur[1:0];
              end
            end
          endcase
        end
        PIO_OP_SETL, PIO_OP_CLRL: begin
          if (la == `PIO_ADDR_WIDE_A) begin
            s_nxt.lat_a = bit_upd(s_r.lat_a, lreg_i[1:0], op_i == PIO_OP_SETL);
          end else begin
            s_nxt.lat_b = bit_upd(s_r.lat_b, lreg_i[1:0], op_i == PIO_OP_SETL);
          end
        end
        default: begin
          s_nxt.cmd_we = 1'b0;
        end
      endcase
    end
  end

  // Latches reset to one so every pin starts as an input
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      s_r         <= '0;
      s_r.lat_a   <= `PIO_WIDE_RESET;
      s_r.lat_b   <= `PIO_WIDE_RESET;
      s_r.lat_n   <= `PIO_NARROW_RESET;
    end else begin
      s_r <= s_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Command registers

  pio_cmd_regs #(
    .WORDS (4),
    .WIDTH (4)
  ) i_pio_cmd_regs (
    .clk_i     (clk_i),
    .rstn_i    (rstn_i),
    .wr_en_i   (s_r.cmd_we),
    .wr_idx_i  (s_r.cmd_idx),
    .wr_data_i (s_r.cmd_wd),
    .q_o       (cmd_q)
  );

  assign hold_mode_command_o      = cmd_q[3:0];
  assign interval_timer_command_o = cmd_q[7:4];
  assign counter_one_command_o    = cmd_q[11:8];
  assign counter_two_command_o    = cmd_q[15:12];

  ////////////////////////////////////////////////////////////////////////
  // Outputs; a latch at one releases the pin so it can be read

  assign rdata_o                 = s_r.rdata;
  assign test_o                  = s_r.test;
  assign rvalid_o                = s_r.rvalid;
  assign illegal_o               = s_r.illegal;
  assign wide_port_a_o           = s_r.lat_a;
  assign wide_port_a_oe_o        = ~s_r.lat_a;
  assign wide_port_b_o           = s_r.lat_b;
  assign wide_port_b_oe_o        = ~s_r.lat_b;
  assign narrow_shared_port_o    = s_r.lat_n;
  // Pin shared with interrupt and counter input only works while latch is one
  assign narrow_shared_port_oe_o = ~s_r.lat_n;

  ////////////////////////////////////////////////////////////////////////
  // Assertions

  AST_LATCH_HOLD: assert property (@(posedge clk_i) disable iff (!rstn_i)
    !s4_hit |=> $stable(wide_port_a_o) && $stable(wide_port_b_o) && $stable(narrow_shared_port_o))
    else $error("Port latch changed outside drive state");

  AST_OUT_A: assert property (@(posedge clk_i) disable iff (!rstn_i)
    s4_hit && op_i == PIO_OP_OUT && port_addr_i == `PIO_ADDR_WIDE_A |=> wide_port_a_o == $past(wdata_i))
    else $error("Wide port A not written in drive state");

  AST_IN_SAMPLE: assert property (@(posedge clk_i) disable iff (!rstn_i)
    s3_hit && op_i == PIO_OP_IN && port_addr_i == `PIO_ADDR_WIDE_B
    |=> rvalid_o && rdata_o == $past(wide_port_b_i))
    else $error("Input not sampled in sample state");

  AST_SENSE_INV: assert property (@(posedge clk_i) disable iff (!rstn_i)
    s3_hit && op_i == PIO_OP_IN && port_addr_i == `PIO_ADDR_SENSE
    |=> rdata_o[0] == !$past(sense_input_port_i))
    else $error("Sense bit not inverted");

  AST_NO_CMD_READ: assert property (@(posedge clk_i) disable iff (!rstn_i)
    s3_hit && op_i == PIO_OP_IN && port_addr_i == `PIO_ADDR_HOLD |=> illegal_o && !rvalid_o)
    else $error("Command port was readable");

  AST_HOLD_CMD: assert property (@(posedge clk_i) disable iff (!rstn_i)
    s4_hit && op_i == PIO_OP_OUT && port_addr_i == `PIO_ADDR_HOLD
    |-> ##2 hold_mode_command_o == $past(wdata_i, 2))
    else $error("Hold command not stored");

  AST_CNT2_CMD: assert property (@(posedge clk_i) disable iff (!rstn_i)
    s4_hit && op_i == PIO_OP_OUTK && port_addr_i == `PIO_ADDR_CNT2
    |-> ##2 $stable(counter_two_command_o))
    else $error("Immediate form reached counter command");

  AST_L_RANGE: assert property (@(posedge clk_i) disable iff (!rstn_i)
    s4_hit && op_i == PIO_OP_CLRL && lreg_i[3] |=> $stable(wide_port_a_o) && $stable(wide_port_b_o))
    else $error("Indirect bit op outside ports 04 and 05");

  AST_NARROW_OUT: assert property (@(posedge clk_i) disable iff (!rstn_i)
    s4_hit && op_i == PIO_OP_OUT && port_addr_i == `PIO_ADDR_NARROW
    |=> narrow_shared_port_o == $past(wdata_i[1:0]))
    else $error("Narrow port not written");

  AST_RVALID_PULSE: assert property (@(posedge clk_i) disable iff (!rstn_i)
    rvalid_o |-> $past(s3_hit) ##1 !rvalid_o)
    else $error("Read result not a single pulse after sample");

  AST_OUT_B: assert property (@(posedge clk_i) disable iff (!rstn_i)
    s4_hit && op_i == PIO_OP_OUTK && port_addr_i == `PIO_ADDR_WIDE_B
    |=> wide_port_b_o == $past(wdata_i))
    else $error("Wide port B not written by immediate form");

  AST_SENSE_UPPER: assert property (@(posedge clk_i) disable iff (!rstn_i)
    s3_hit && op_i == PIO_OP_IN && port_addr_i == `PIO_ADDR_SENSE
    |=> rdata_o[3:1] == 3'h0)
    else $error("Sense status upper bits not zero");

  AST_ILLEGAL_PULSE: assert property (@(posedge clk_i) disable iff (!rstn_i)
    illegal_o |=> !illegal_o)
    else $error("Refusal flag longer than one cycle");

  // Command outputs lag the drive edge by two clocks
  AST_ITMR_CMD: assert property (@(posedge clk_i) disable iff (!rstn_i)
    s4_hit && op_i == PIO_OP_OUT && port_addr_i == `PIO_ADDR_ITMR
    |-> ##2 interval_timer_command_o == $past(wdata_i, 2))
    else $error("Interval timer command not stored");

  AST_CNT1_CMD: assert property (@(posedge clk_i) disable iff (!rstn_i)
    s4_hit && op_i == PIO_OP_OUT && port_addr_i == `PIO_ADDR_CNT1
    |-> ##2 counter_one_command_o == $past(wdata_i, 2))
    else $error("First counter command not stored");

  AST_REFUSED_NO_CMD: assert property (@(posedge clk_i) disable iff (!rstn_i)
    s4_hit && !legal |-> ##2 $stable(hold_mode_command_o) && $stable(interval_timer_command_o)
    && $stable(counter_one_command_o) && $stable(counter_two_command_o))
    else $error("Refused form changed a command register");

endmodule // pio_port_decoder
`default_nettype wire

// >>> include/pio_cfg.svh
// Port addresses, field positions, reset values and state codes of the port block
// Overview of operation
// - Decode port addresses from 00H, one per port
// - Target port comes from instruction address, or from L for the indirect bit forms
// - Status ports read, command ports control internals
// - Input pins sampled in second-cycle sample state
// - Sampled inputs pass unfiltered; software debounces
// - Outputs update in second-cycle drive state
// - Output latches hold data until next write
// - Two 4-bit latched bidirectional ports, 04, 05
// - 2-bit latched port at 08, shared pins
// - Inverted sense input readable at status 0E
// - Write-only hold mode command at 10
// - Write-only interval timer command at 19
// - Write-only first counter command at 1C
// - Write-only second counter command at 1D
// - Port latches reset to one; one means input
// - Sense bit inverted in LSB; upper bits read zero
`ifndef PIO_CFG_SVH
`define PIO_CFG_SVH

`define PIO_ADDR_W        5
`define PIO_ADDR_WIDE_A   5'h04
`define PIO_ADDR_WIDE_B   5'h05
`define PIO_ADDR_NARROW   5'h08
`define PIO_ADDR_SENSE    5'h0e
`define PIO_ADDR_HOLD     5'h10
`define PIO_ADDR_ITMR     5'h19
`define PIO_ADDR_CNT1     5'h1c
`define PIO_ADDR_CNT2     5'h1d

`define PIO_CMD_IDX_HOLD  2'h0
`define PIO_CMD_IDX_ITMR  2'h1
`define PIO_CMD_IDX_CNT1  2'h2
`define PIO_CMD_IDX_CNT2  2'h3
`define PIO_CMD_RESET     4'h0

`define PIO_WIDE_RESET    4'hf
`define PIO_NARROW_RESET  2'h3
`define PIO_UNDEF_READ    4'h0

`define PIO_ST_SAMPLE     2'h2
`define PIO_ST_DRIVE      2'h3

`define PIO_LREG_PORT_A   2'h0
`define PIO_LREG_PORT_B   2'h1

`endif

// >>> include/pio_pkg.sv
// Types shared by the port block
`default_nettype none
package pio_pkg;
  typedef enum logic [3:0] {
    PIO_OP_NONE  = 4'h0,
    PIO_OP_IN    = 4'h1,
    PIO_OP_OUT   = 4'h2,
    PIO_OP_OUTK  = 4'h3,
    PIO_OP_OUTB  = 4'h4,
    PIO_OP_SETP  = 4'h5,
    PIO_OP_CLRP  = 4'h6,
    PIO_OP_TESTP = 4'h7,
    PIO_OP_SETL  = 4'h8,
    PIO_OP_CLRL  = 4'h9,
    PIO_OP_TESTL = 4'ha
  } pio_op_t;
endpackage
`default_nettype wire

// >>> core/pio_cmd_regs.sv
// Write-only command register file feeding internal circuits
`default_nettype none
`include "pio_cfg.svh"
module pio_cmd_regs #(
  parameter int WORDS = 4,
  parameter int WIDTH = 4
) (
  input  wire logic                     clk_i,
  input  wire logic                     rstn_i,
  input  wire logic                     wr_en_i,
  input  wire logic [1:0]               wr_idx_i,
  input  wire logic [WIDTH-1:0]         wr_data_i,
  output logic      [WORDS*WIDTH-1:0]   q_o
);
  typedef struct packed {
    logic [WORDS-1:0][WIDTH-1:0] mem;
  } pio_cmd_state_t;

  pio_cmd_state_t s_r;
  pio_cmd_state_t s_nxt;

  always_comb begin
    s_nxt = s_r;
    if (wr_en_i) begin
      s_nxt.mem[wr_idx_i] = wr_data_i;
    end
  end

  // Command registers clear at reset
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign q_o = s_r.mem;
endmodule // pio_cmd_regs
`default_nettype wire

// >>> sim/pio_pins_model.sv
// Pin-side partner: open-drain wires shared with external sources
`default_nettype none
module pio_pins_model (
  input  wire logic [3:0]  a_out_i,
  input  wire logic [3:0]  a_oe_i,
  input  wire logic [3:0]  b_out_i,
  input  wire logic [3:0]  b_oe_i,
  input  wire logic [1:0]  n_out_i,
  input  wire logic [1:0]  n_oe_i,
  input  wire logic [10:0] ext_i,
  output logic      [3:0]  a_pin_o,
  output logic      [3:0]  b_pin_o,
  output logic      [1:0]  n_pin_o,
  output logic             sense_pin_o
);
  timeunit 1ns;
  timeprecision 100ps;
  // Source level is whatever the bench holds this state
  // Shared pins see the source only while the latch is one
  assign a_pin_o     = (a_oe_i & a_out_i) | (~a_oe_i & ext_i[3:0]);
  assign b_pin_o     = (b_oe_i & b_out_i) | (~b_oe_i & ext_i[7:4]);
  assign n_pin_o     = (n_oe_i & n_out_i) | (~n_oe_i & ext_i[9:8]);
  assign sense_pin_o = ext_i[10];
endmodule // pio_pins_model
`default_nettype wire

// >>> sim/tb.sv
// Self-checking bench for the port address decoder
`default_nettype none
`include "pio_cfg.svh"
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  import pio_pkg::*;
  logic clk, rstn, io_req, cyc2, test, rvalid, illegal, sense_pin;
  logic [1:0] state, bit_sel, n_o, n_oe, n_pin;
  logic [3:0] wdata, lreg, rdata, a_o, a_oe, b_o, b_oe, a_pin, b_pin, hc, ic, c1, c2, exp_a, exp_b;
  logic [4:0] addr;
  logic [1:0] exp_n;
  logic [10:0] ext;
  logic [15:0] seed, exp_cmd;
  pio_op_t op;
  int miscompares, checked;

  pio_port_decoder i_pio_port_decoder (.clk_i(clk), .rstn_i(rstn), .io_req_i(io_req), .op_i(op),
    .port_addr_i(addr), .wdata_i(wdata), .bit_sel_i(bit_sel), .lreg_i(lreg), .cyc2_i(cyc2),
    .state_i(state), .rdata_o(rdata), .test_o(test), .rvalid_o(rvalid), .illegal_o(illegal),
    .wide_port_a_i(a_pin), .wide_port_a_o(a_o), .wide_port_a_oe_o(a_oe), .wide_port_b_i(b_pin),
    .wide_port_b_o(b_o), .wide_port_b_oe_o(b_oe), .narrow_shared_port_i(n_pin),
    .narrow_shared_port_o(n_o), .narrow_shared_port_oe_o(n_oe), .sense_input_port_i(sense_pin),
    .hold_mode_command_o(hc), .interval_timer_command_o(ic), .counter_one_command_o(c1),
    .counter_two_command_o(c2));
  pio_pins_model i_pio_pins_model (.a_out_i(a_o), .a_oe_i(a_oe), .b_out_i(b_o), .b_oe_i(b_oe),
    .n_out_i(n_o), .n_oe_i(n_oe), .ext_i(ext), .a_pin_o(a_pin), .b_pin_o(b_pin), .n_pin_o(n_pin),
    .sense_pin_o(sense_pin));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  function automatic void next_rnd();
    seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
  endfunction

  // Random picks land on mapped ports; the sweep covers the reserved ones
  function automatic logic [4:0] pick_addr(input logic [2:0] r);
    case (r)
      3'h0: return `PIO_ADDR_WIDE_A;
      3'h1: return `PIO_ADDR_WIDE_B;
      3'h2: return `PIO_ADDR_NARROW;
      3'h3: return `PIO_ADDR_SENSE;
      3'h4: return `PIO_ADDR_HOLD;
      3'h5: return `PIO_ADDR_ITMR;
      3'h6: return `PIO_ADDR_CNT1;
      default: return `PIO_ADDR_CNT2;
    endcase
  endfunction

  function automatic logic legal(input pio_op_t o, input logic [4:0] p, input logic [3:0] l);
    logic io;
    io = (p == `PIO_ADDR_WIDE_A) || (p == `PIO_ADDR_WIDE_B) || (p == `PIO_ADDR_NARROW);
    case (o)
      PIO_OP_IN: return io || (p == `PIO_ADDR_SENSE);
      PIO_OP_OUT: return io || (p == `PIO_ADDR_HOLD) || (p == `PIO_ADDR_ITMR) || (p == `PIO_ADDR_CNT1)
                         || (p == `PIO_ADDR_CNT2);
      PIO_OP_OUTK, PIO_OP_SETP, PIO_OP_CLRP, PIO_OP_TESTP: return io;
      PIO_OP_SETL, PIO_OP_CLRL, PIO_OP_TESTL: return !l[3];
      default: return 1'b0;
    endcase
  endfunction

  task automatic check_state();
    chk({a_o, b_o, 2'h0, n_o}, {exp_a, exp_b, 2'h0, exp_n});
    chk({a_oe, b_oe, 2'h0, n_oe}, {~exp_a, ~exp_b, 2'h0, ~exp_n});
    chk({c2, c1, ic, hc}, exp_cmd);
  endtask

  task automatic do_reset();
    rstn = 1'b0;
    repeat (12) @(posedge clk);
    #1 rstn = 1'b1;
    exp_a = `PIO_WIDE_RESET;
    exp_b = `PIO_WIDE_RESET;
    exp_n = `PIO_NARROW_RESET;
    exp_cmd = 16'h0000;
    check_state();
    chk({rvalid, illegal, test, rdata}, 16'h0000);
  endtask

  // One two-cycle instruction; pins change every state, so a late or early sample shows
  task automatic instr(input pio_op_t o, input logic [4:0] p, input logic [3:0] wd, input logic [1:0] bs,
                       input logic [3:0] l);
    logic [10:0] smp;
    logic ok, v, rv;
    logic [3:0] pa, pb, rd;
    logic [1:0] pn;
    for (int c = 0; c < 2; c++) begin
      for (int s = 0; s < 4; s++) begin
        @(posedge clk);
        #1;
        op = o;
        {io_req, addr, wdata, bit_sel, lreg} = {1'b1, p, wd, bs, l};
        {cyc2, state} = {c[0], s[1:0]};
        next_rnd();
        ext = seed[10:0];
        if (c == 1 && s == 2) smp = ext;
      end
    end
    ok = legal(o, p, l);
    pa = exp_a & smp[3:0];
    pb = exp_b & smp[7:4];
    pn = exp_n & smp[9:8];
    rv = ok && (o == PIO_OP_IN || o == PIO_OP_TESTP || o == PIO_OP_TESTL);
    chk({rvalid, illegal}, {rv, !ok});
    chk({a_o, b_o, n_o}, {exp_a, exp_b, exp_n});
    rd = (p == `PIO_ADDR_WIDE_A) ? pa : (p == `PIO_ADDR_WIDE_B) ? pb :
         (p == `PIO_ADDR_NARROW) ? {2'h0, pn} : {3'h0, ~smp[10]};
    if (ok && o == PIO_OP_IN) chk(rdata, rd);
    if (ok && o == PIO_OP_TESTP) chk(test, rd[bs]);
    if (ok && o == PIO_OP_TESTL) chk(test, l[2] ? pb[l[1:0]] : pa[l[1:0]]);
    v = (o == PIO_OP_SETP) || (o == PIO_OP_SETL);
    if (ok && (o == PIO_OP_OUT || o == PIO_OP_OUTK)) begin
      case (p)
        `PIO_ADDR_WIDE_A: exp_a = wd;
        `PIO_ADDR_WIDE_B: exp_b = wd;
        `PIO_ADDR_NARROW: exp_n = wd[1:0];
        `PIO_ADDR_HOLD: exp_cmd[3:0] = wd;
        `PIO_ADDR_ITMR: exp_cmd[7:4] = wd;
        `PIO_ADDR_CNT1: exp_cmd[11:8] = wd;
        default: exp_cmd[15:12] = wd;
      endcase
    end
    if (ok && (o == PIO_OP_SETP || o == PIO_OP_CLRP)) begin
      if (p == `PIO_ADDR_WIDE_A) exp_a[bs] = v;
      else if (p == `PIO_ADDR_WIDE_B) exp_b[bs] = v;
      else if (!bs[1]) exp_n[bs[0]] = v;
    end
    if (ok && (o == PIO_OP_SETL || o == PIO_OP_CLRL)) begin
      if (l[2]) exp_b[l[1:0]] = v;
      else exp_a[l[1:0]] = v;
    end
    @(posedge clk);
    #1;
    {io_req, cyc2, state} = {1'b0, 1'b0, 2'h0};
    op = PIO_OP_NONE;
    chk({rvalid, illegal, a_o, b_o, n_o}, {2'h0, exp_a, exp_b, exp_n});
    @(posedge clk);
    #1;
    check_state();
  endtask

  task automatic stop_test();
    $display("Counts: checked=%0d miscompares=%0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  initial begin
    repeat (50000) @(posedge clk);
    miscompares++;
    stop_test();
  end

  initial begin
    {io_req, cyc2, state, wdata, bit_sel, lreg, addr, ext} = '0;
    op = PIO_OP_NONE;
    seed = 16'h0063;
    miscompares = 0;
    checked = 0;
    do_reset();
    $display("Test reset done");
    // Every form at every address, reserved places included
    for (int k = 1; k < 11; k++) begin
      for (int p = 0; p < 32; p++) begin
        next_rnd();
        instr(pio_op_t'(k), p[4:0], seed[3:0], seed[5:4], seed[9:6]);
      end
    end
    $display("Test sweep done");
    // Bit 2 and 3 at the narrow port must leave it alone
    instr(PIO_OP_CLRP, `PIO_ADDR_NARROW, 4'h0, 2'h2, 4'h0);
    instr(PIO_OP_CLRP, `PIO_ADDR_NARROW, 4'h0, 2'h3, 4'h0);
    for (int i = 0; i < 400; i++) begin
      next_rnd();
      instr(pio_op_t'(4'h1 + seed[15:12] % 4'ha), pick_addr(seed[2:0]),
            seed[7:4], seed[9:8], {1'b0, seed[11:9]});
    end
    $display("Test random done");
    do_reset();
    $display("Test second reset done");
    stop_test();
  end
endmodule // tb
`default_nettype wire
